/* File: rtl/ident_gpio_history_regs.sv */
// Identity, pin configuration and history control registers behind a two-wire serial slave.
// Assumes scl_i and sda_i are already synchronous to sys_clk; the pad resolves sda from sda_oe.
`timescale 1ns/100ps

// Operation
// - Model code register sits at index zero
// - Revision fields 3 bits, reloaded at boot
// - Upper date: year digit and month
// - Lower date: day and phase
// - 16-bit build time, seconds are twice it
// - Pin0 shutdown priority overrides other fields
// - Polarity 0 active low, 1 high
// - Function 0000 released, 1000 interrupt output
// - Host sets clear, device drops it after
// - Mode selects ranging or ambient history
// - Enable bit turns history buffering on
module ident_gpio_history_regs #(
  parameter logic [6:0] BUS_ADDR = 7'h2a,
  parameter logic [7:0] MODEL_CODE_RESET = 8'h5a, // arbitrary value
  parameter logic [2:0] MODEL_REV_HIGH_RESET = 3'h5, // arbitrary value
  parameter logic [2:0] MODEL_REV_LOW_RESET = 3'h6, // arbitrary value
  parameter logic [2:0] MODULE_REV_HIGH_RESET = 3'h4, // arbitrary value
  parameter logic [2:0] MODULE_REV_LOW_RESET = 3'h7, // arbitrary value
  parameter int HIST_DEPTH = sensor_regs_pkg::HISTORY_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Two-wire serial bus, sda open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Boot load from the nonvolatile store
  input wire logic nvs_load,
  input wire sensor_regs_pkg::ident_t nvs_ident,
  // Interrupt level from the measurement core
  input wire logic irq_level,
  // General pins
  input wire logic pin0_i,
  output logic pin0_o,
  output logic pin0_oe,
  input wire logic pin1_i,
  output logic pin1_o,
  output logic pin1_oe,
  output logic shutdown_req,
  // History buffer control
  output logic hist_enable,
  output logic hist_mode_als,
  output logic hist_clear_strobe,
  output logic [$clog2(HIST_DEPTH)-1:0] hist_clear_index,
  // Identity views
  output logic [7:0] model_code,
  output logic [16:0] build_seconds
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  localparam sensor_regs_pkg::ident_t IDENT_RESET = '{
    model_code: MODEL_CODE_RESET,
    model_rev_high: MODEL_REV_HIGH_RESET,
    model_rev_low: MODEL_REV_LOW_RESET,
    module_rev_high: MODULE_REV_HIGH_RESET,
    module_rev_low: MODULE_REV_LOW_RESET,
    build_year_digit: sensor_regs_pkg::DATE_RESET[7:4],
    build_month: sensor_regs_pkg::DATE_RESET[3:0],
    build_day: sensor_regs_pkg::DATE_RESET[7:3],
    build_phase: sensor_regs_pkg::DATE_RESET[2:0],
    build_time: sensor_regs_pkg::TIME_RESET
  };

  sensor_regs_pkg::ser_state_t state_q, state_d;
  logic ack_q, ack_d;
  logic own_q, own_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [15:0] idx_q, idx_d;
  logic scl_q, sda_q;
  logic start_cond, stop_cond, scl_rise, scl_fall;
  logic wr_en;
  logic [7:0] rdata;

  sensor_regs_pkg::ident_t id_q, id_d;
  sensor_regs_pkg::pin_cfg_t pin0_q, pin0_d, pin1_q, pin1_d;
  sensor_regs_pkg::hist_ctrl_t hist_q, hist_d;
  logic clear_done;
  logic sd0;

  // ---------------------------------------------------------------------------
  // Bus line sampling and conditions
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // Start and stop are sda edges while scl stays high
  assign start_cond = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_cond = scl_i & scl_q & ~sda_q & sda_i;
  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;

  // ---------------------------------------------------------------------------
  // Serial slave next state
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ack_d = ack_q;
    own_d = own_q;
    bit_d = bit_q;
    sh_d = sh_q;
    idx_d = idx_q;
    wr_en = 1'b0;
    if (start_cond) begin
      state_d = sensor_regs_pkg::SER_ADDR;
      bit_d = '0;
      ack_d = 1'b0;
      own_d = 1'b0;
    end else if (stop_cond) begin
      state_d = sensor_regs_pkg::SER_IDLE;
      ack_d = 1'b0;
      own_d = 1'b0;
    end else if (state_q != sensor_regs_pkg::SER_IDLE) begin
      if (scl_rise) begin
        if (ack_q) begin
          // Master not acknowledging a read byte ends the read
          if (state_q == sensor_regs_pkg::SER_RDATA && sda_i) begin
            state_d = sensor_regs_pkg::SER_IDLE;
            ack_d = 1'b0;
          end
        end else begin
          if (state_q != sensor_regs_pkg::SER_RDATA) begin
            sh_d = {sh_q[6:0], sda_i};
          end
          bit_d = bit_q + 1'b1;
        end
      end else if (scl_fall) begin
        if (ack_q) begin
          // End of acknowledge slot
          ack_d = 1'b0;
          own_d = 1'b0;
          bit_d = '0;
          if (state_q == sensor_regs_pkg::SER_RDATA) begin
            sh_d = rdata;
            idx_d = idx_q + 1'b1;
          end
        end else if (bit_q == sensor_regs_pkg::I2C_BYTE_BITS) begin
          ack_d = 1'b1;
          case (state_q)
            sensor_regs_pkg::SER_ADDR: begin
              if (sh_q[7:1] == BUS_ADDR) begin
                own_d = 1'b1;
                state_d = sh_q[0] ? sensor_regs_pkg::SER_RDATA : sensor_regs_pkg::SER_IDX_HI;
              end else begin
                state_d = sensor_regs_pkg::SER_IDLE;
              end
            end
            sensor_regs_pkg::SER_IDX_HI: begin
              idx_d[15:8] = sh_q;
              own_d = 1'b1;
              state_d = sensor_regs_pkg::SER_IDX_LO;
            end
            sensor_regs_pkg::SER_IDX_LO: begin
              idx_d[7:0] = sh_q;
              own_d = 1'b1;
              state_d = sensor_regs_pkg::SER_WDATA;
            end
            sensor_regs_pkg::SER_WDATA: begin
              wr_en = 1'b1;
              idx_d = idx_q + 1'b1;
              own_d = 1'b1;
            end
            default: own_d = 1'b0;
          endcase
        end else if (state_q == sensor_regs_pkg::SER_RDATA) begin
          sh_d = {sh_q[6:0], 1'b0};
        end
      end
    end
  end

  // Serial slave registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= sensor_regs_pkg::SER_IDLE;
      ack_q <= 1'b0;
      own_q <= 1'b0;
      bit_q <= '0;
      sh_q <= '0;
      idx_q <= '0;
    end else begin
      state_q <= state_d;
      ack_q <= ack_d;
      own_q <= own_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      idx_q <= idx_d;
    end
  end

  // Open-drain data: pull low for our acknowledge or a zero read bit
  assign sda_o = 1'b0;
  assign sda_oe = own_q | ((state_q == sensor_regs_pkg::SER_RDATA) & ~ack_q & ~sh_q[7]);

  // ---------------------------------------------------------------------------
  // Read data select
  // ---------------------------------------------------------------------------
  always_comb begin
    case (idx_q)
      sensor_regs_pkg::OFS_MODEL_IDENT: rdata = id_q.model_code;
      sensor_regs_pkg::OFS_MODEL_REV_HIGH: rdata = {5'h00, id_q.model_rev_high};
      sensor_regs_pkg::OFS_MODEL_REV_LOW: rdata = {5'h00, id_q.model_rev_low};
      sensor_regs_pkg::OFS_MODULE_REV_HIGH: rdata = {5'h00, id_q.module_rev_high};
      sensor_regs_pkg::OFS_MODULE_REV_LOW: rdata = {5'h00, id_q.module_rev_low};
      sensor_regs_pkg::OFS_BUILD_DATE_UPPER: rdata = {id_q.build_year_digit, id_q.build_month};
      sensor_regs_pkg::OFS_BUILD_DATE_LOWER: rdata = {id_q.build_day, id_q.build_phase};
      sensor_regs_pkg::OFS_BUILD_TIME_HIGH: rdata = id_q.build_time[15:8];
      sensor_regs_pkg::OFS_BUILD_TIME_LOW: rdata = id_q.build_time[7:0];
      sensor_regs_pkg::OFS_PIN0_CONFIG: rdata = {1'b0, pin0_q, 1'b0};
      sensor_regs_pkg::OFS_PIN1_CONFIG: rdata = {1'b0, pin1_q, 1'b0};
      sensor_regs_pkg::OFS_HISTORY_CONTROL: rdata = {5'h00, hist_q};
      default: rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Register file next state
  // ---------------------------------------------------------------------------
  always_comb begin
    id_d = id_q;
    pin0_d = pin0_q;
    pin1_d = pin1_q;
    hist_d = hist_q;
    // Clear completion drops the bit; a host write this cycle overrides it
    if (clear_done) begin
      hist_d.clear = 1'b0;
    end
    if (wr_en) begin
      case (idx_q)
        sensor_regs_pkg::OFS_MODEL_IDENT: id_d.model_code = sh_q;
        sensor_regs_pkg::OFS_MODEL_REV_HIGH: id_d.model_rev_high = sh_q[2:0];
        sensor_regs_pkg::OFS_MODEL_REV_LOW: id_d.model_rev_low = sh_q[2:0];
        sensor_regs_pkg::OFS_MODULE_REV_HIGH: id_d.module_rev_high = sh_q[2:0];
        sensor_regs_pkg::OFS_MODULE_REV_LOW: id_d.module_rev_low = sh_q[2:0];
        sensor_regs_pkg::OFS_BUILD_DATE_UPPER: {id_d.build_year_digit, id_d.build_month} = sh_q;
        sensor_regs_pkg::OFS_BUILD_DATE_LOWER: {id_d.build_day, id_d.build_phase} = sh_q;
        sensor_regs_pkg::OFS_BUILD_TIME_HIGH: id_d.build_time[15:8] = sh_q;
        sensor_regs_pkg::OFS_BUILD_TIME_LOW: id_d.build_time[7:0] = sh_q;
        sensor_regs_pkg::OFS_PIN0_CONFIG: begin
          pin0_d = sh_q[sensor_regs_pkg::PIN_FIELD_MSB:sensor_regs_pkg::PIN_FIELD_LSB];
        end
        sensor_regs_pkg::OFS_PIN1_CONFIG: begin
          pin1_d = sh_q[sensor_regs_pkg::PIN_FIELD_MSB:sensor_regs_pkg::PIN_FIELD_LSB]
            & sensor_regs_pkg::PIN1_WRITE_MASK[sensor_regs_pkg::PIN_FIELD_MSB:sensor_regs_pkg::PIN_FIELD_LSB];
        end
        sensor_regs_pkg::OFS_HISTORY_CONTROL: hist_d = sh_q[sensor_regs_pkg::HIST_FIELD_MSB:0];
        default: hist_d = hist_d;
      endcase
    end
    // Boot load replaces every identity default
    if (nvs_load) begin
      id_d = nvs_ident;
    end
  end

  // Register file
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      id_q <= IDENT_RESET;
      pin0_q <= sensor_regs_pkg::PIN0_RESET[sensor_regs_pkg::PIN_FIELD_MSB:sensor_regs_pkg::PIN_FIELD_LSB];
      pin1_q <= sensor_regs_pkg::PIN1_RESET[sensor_regs_pkg::PIN_FIELD_MSB:sensor_regs_pkg::PIN_FIELD_LSB];
      hist_q <= sensor_regs_pkg::HIST_RESET[sensor_regs_pkg::HIST_FIELD_MSB:0];
    end else begin
      id_q <= id_d;
      pin0_q <= pin0_d;
      pin1_q <= pin1_d;
      hist_q <= hist_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Pins and history sequencer
  // ---------------------------------------------------------------------------
  pin_config_unit #(
    .HAS_SHUTDOWN(1'b1)
  ) u_pin0 (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg(pin0_q),
    .irq_level(irq_level),
    .pin_i(pin0_i),
    .pin_o(pin0_o),
    .pin_oe(pin0_oe),
    .shutdown_req(sd0)
  );

  pin_config_unit #(
    .HAS_SHUTDOWN(1'b0)
  ) u_pin1 (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg(pin1_q),
    .irq_level(irq_level),
    .pin_i(pin1_i),
    .pin_o(pin1_o),
    .pin_oe(pin1_oe),
    .shutdown_req()
  );

  history_clear_seq #(
    .DEPTH(HIST_DEPTH)
  ) u_hclear (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(hist_q.clear),
    .clear_strobe(hist_clear_strobe),
    .clear_index(hist_clear_index),
    .done(clear_done)
  );

  // Control and identity views, all from flip-flops
  assign shutdown_req = sd0;
  assign hist_enable = hist_q.enable;
  assign hist_mode_als = hist_q.mode_als;
  assign model_code = id_q.model_code;
  assign build_seconds = {id_q.build_time, 1'b0};

endmodule : ident_gpio_history_regs

/* File: rtl/sensor_regs_pkg.sv */
// Shared constants and types for the identity, pin and history register bank.
// Assumes a single 250 MHz clock and a two-wire serial host with 16-bit register indexes.
package sensor_regs_pkg;

  // ---------------------------------------------------------------------------
  // Register indexes
  // ---------------------------------------------------------------------------
  localparam logic [15:0] OFS_MODEL_IDENT = 16'h0000;
  localparam logic [15:0] OFS_MODEL_REV_HIGH = 16'h0001;
  localparam logic [15:0] OFS_MODEL_REV_LOW = 16'h0002;
  localparam logic [15:0] OFS_MODULE_REV_HIGH = 16'h0003;
  localparam logic [15:0] OFS_MODULE_REV_LOW = 16'h0004;
  localparam logic [15:0] OFS_BUILD_DATE_UPPER = 16'h0006;
  localparam logic [15:0] OFS_BUILD_DATE_LOWER = 16'h0007;
  localparam logic [15:0] OFS_BUILD_TIME_HIGH = 16'h0008;
  localparam logic [15:0] OFS_BUILD_TIME_LOW = 16'h0009;
  localparam logic [15:0] OFS_PIN0_CONFIG = 16'h0010;
  localparam logic [15:0] OFS_PIN1_CONFIG = 16'h0011;
  localparam logic [15:0] OFS_HISTORY_CONTROL = 16'h0012;

  // ---------------------------------------------------------------------------
  // Field layouts
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] model_code;
    logic [2:0] model_rev_high;
    logic [2:0] model_rev_low;
    logic [2:0] module_rev_high;
    logic [2:0] module_rev_low;
    logic [3:0] build_year_digit;
    logic [3:0] build_month;
    logic [4:0] build_day;
    logic [2:0] build_phase;
    logic [15:0] build_time;
  } ident_t;

  // Pin configuration byte holds these fields in bits 6 down to 1
  typedef struct packed {
    logic shutdown_priority;
    logic polarity;
    logic [3:0] function_sel;
  } pin_cfg_t;

  // History control byte holds these fields in bits 2 down to 0
  typedef struct packed {
    logic clear;
    logic mode_als;
    logic enable;
  } hist_ctrl_t;

  localparam int PIN_FIELD_LSB = 1;
  localparam int PIN_FIELD_MSB = 6;
  localparam int HIST_FIELD_MSB = 2;
  localparam logic [7:0] PIN1_WRITE_MASK = 8'h3e;

  // ---------------------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PIN0_RESET = 8'h60;
  localparam logic [7:0] PIN1_RESET = 8'h20;
  localparam logic [7:0] HIST_RESET = 8'h00;
  localparam logic [7:0] DATE_RESET = 8'h00;
  localparam logic [15:0] TIME_RESET = 16'h0000;
  localparam logic [3:0] FUNC_OFF = 4'h0;
  localparam logic [3:0] FUNC_IRQ = 4'h8;
  localparam int HISTORY_DEPTH = 8;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

  // Serial front end states, Gray coded along the write path
  typedef enum logic [2:0] {
    SER_IDLE = 3'h0,
    SER_ADDR = 3'h1,
    SER_IDX_HI = 3'h3,
    SER_IDX_LO = 3'h2,
    SER_WDATA = 3'h6,
    SER_RDATA = 3'h7
  } ser_state_t;

  typedef enum logic [1:0] {
    HC_IDLE = 2'h0,
    HC_RUN = 2'h1,
    HC_DONE = 2'h3
  } hc_state_t;

endpackage : sensor_regs_pkg

/* File: rtl/pin_config_unit.sv */
// One general-purpose pin: interrupt output, high impedance or shutdown input.
// Assumes the configuration comes from the register bank and irq_level from the measurement core.
`timescale 1ns/100ps
module pin_config_unit #(
  parameter bit HAS_SHUTDOWN = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration and event
  input wire sensor_regs_pkg::pin_cfg_t cfg,
  input wire logic irq_level,
  // Pin
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  // Shutdown request, high while the pin asks for shutdown
  output logic shutdown_req
);

  logic pin_o_d, pin_oe_d, shutdown_d;

  // ---------------------------------------------------------------------------
  // Pin function decode
  // ---------------------------------------------------------------------------
  always_comb begin
    pin_o_d = 1'b0;
    pin_oe_d = 1'b0;
    shutdown_d = 1'b0;
    if (HAS_SHUTDOWN && cfg.shutdown_priority) begin
      // Other fields ignored; pin is an active-low shutdown input
      shutdown_d = ~pin_i;
    end else if (cfg.function_sel == sensor_regs_pkg::FUNC_IRQ) begin
      pin_oe_d = 1'b1;
      pin_o_d = irq_level ? cfg.polarity : ~cfg.polarity;
    end
    // FUNC_OFF and unused codes leave the pin released
  end

  // Output registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
      shutdown_req <= 1'b0;
    end else begin
      pin_o <= pin_o_d;
      pin_oe <= pin_oe_d;
      shutdown_req <= shutdown_d;
    end
  end

endmodule : pin_config_unit

/* File: rtl/history_clear_seq.sv */
// Walks every history entry with a clear strobe, then reports completion.
// Assumes the history store clears the entry named by clear_index while clear_strobe is high.
`timescale 1ns/100ps
module history_clear_seq #(
  parameter int DEPTH = sensor_regs_pkg::HISTORY_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Request level from the control register
  input wire logic start,
  // Towards the history store
  output logic clear_strobe,
  output logic [$clog2(DEPTH)-1:0] clear_index,
  // One-cycle completion pulse
  output logic done
);

  localparam logic [$clog2(DEPTH)-1:0] LAST = ($clog2(DEPTH))'(DEPTH - 1);

  sensor_regs_pkg::hc_state_t state_q, state_d;
  logic [$clog2(DEPTH)-1:0] idx_q, idx_d;

  // ---------------------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    case (state_q)
      sensor_regs_pkg::HC_IDLE: begin
        if (start) begin
          state_d = sensor_regs_pkg::HC_RUN;
          idx_d = '0;
        end
      end
      sensor_regs_pkg::HC_RUN: begin
        if (idx_q == LAST) begin
          state_d = sensor_regs_pkg::HC_DONE;
        end else begin
          idx_d = idx_q + 1'b1;
        end
      end
      sensor_regs_pkg::HC_DONE: state_d = sensor_regs_pkg::HC_IDLE;
      default: state_d = sensor_regs_pkg::HC_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= sensor_regs_pkg::HC_IDLE;
      idx_q <= '0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
    end
  end

  assign clear_strobe = (state_q == sensor_regs_pkg::HC_RUN);
  assign clear_index = idx_q;
  assign done = (state_q == sensor_regs_pkg::HC_DONE);

endmodule : history_clear_seq

/* File: dv/i2c_host_model.sv */
// Two-wire host model: start, stop, byte write with acknowledge check and byte read with not-acknowledge.
// Assumes the bench resolves sda from host_low, the device enable and a pull-up.
`timescale 1ns/100ps
module i2c_host_model (
  // Clock
  input wire logic sys_clk,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic host_low
);
  // ----
  // Bus phases
  // ----
  int nacks = 0;
  initial begin
    scl = 1'b1;
    host_low = 1'b0;
  end
  // Each line level is held for four clocks
  task automatic sclk(input logic s);
    @(posedge sys_clk);
    scl <= s;
    repeat (3) @(posedge sys_clk);
  endtask : sclk
  task automatic sdat(input logic d);
    @(posedge sys_clk);
    host_low <= !d;
    repeat (3) @(posedge sys_clk);
  endtask : sdat
  task automatic start();
    sdat(1'b1);
    sclk(1'b1);
    sdat(1'b0);
    sclk(1'b0);
  endtask : start
  task automatic stop();
    sdat(1'b0);
    sclk(1'b1);
    sdat(1'b1);
  endtask : stop
  // One bit out and the wire level seen while scl is high
  task automatic xfer(input logic d, output logic q);
    sdat(d);
    sclk(1'b1);
    #1 q = sda;
    sclk(1'b0);
  endtask : xfer
  task automatic byte_w(input logic [7:0] v);
    logic q;
    for (int i = 7; i >= 0; i--) xfer(v[i], q);
    xfer(1'b1, q);
    if (q) nacks++;
  endtask : byte_w
  // Released sda while reading, then a closing not-acknowledge
  task automatic byte_r(output logic [7:0] v);
    logic q;
    for (int i = 7; i >= 0; i--) xfer(1'b1, v[i]);
    xfer(1'b1, q);
  endtask : byte_r
  // Index most significant byte first, bit 0 of reserved fields left to the caller
  task automatic write_reg(input logic [6:0] a, input logic [15:0] idx, input logic [7:0] d);
    start();
    byte_w({a, 1'b0});
    byte_w(idx[15:8]);
    byte_w(idx[7:0]);
    byte_w(d);
    stop();
  endtask : write_reg
  task automatic read_reg(input logic [6:0] a, input logic [15:0] idx, output logic [7:0] d);
    start();
    byte_w({a, 1'b0});
    byte_w(idx[15:8]);
    byte_w(idx[7:0]);
    start();
    byte_w({a, 1'b1});
    byte_r(d);
    stop();
  endtask : read_reg
endmodule : i2c_host_model

/* File: dv/ident_gpio_history_regs_asserts.sv */
// Checker for the register bank's pin, history and identity outputs.
// Assumes the bench holds nvs_ident steady around each load pulse.
`timescale 1ns/100ps
module ident_gpio_history_regs_asserts #(
  parameter int HIST_DEPTH = sensor_regs_pkg::HISTORY_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Watched ports
  input wire logic nvs_load,
  input wire sensor_regs_pkg::ident_t nvs_ident,
  input wire logic irq_level,
  input wire logic pin0_i,
  input wire logic pin0_oe,
  input wire logic pin1_o,
  input wire logic pin1_oe,
  input wire logic shutdown_req,
  input wire logic hist_enable,
  input wire logic hist_mode_als,
  input wire logic hist_clear_strobe,
  input wire logic [$clog2(HIST_DEPTH)-1:0] hist_clear_index,
  input wire logic [7:0] model_code,
  input wire logic [16:0] build_seconds
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_model_load: assert property (nvs_load |=> model_code == nvs_ident.model_code)
    else $error("model code not loaded");
  a_seconds_load: assert property (nvs_load |=> build_seconds == {nvs_ident.build_time, 1'b0})
    else $error("build seconds not twice the time");
  a_clear_length: assert property ($rose(hist_clear_strobe) |-> hist_clear_strobe [*8] ##1 !hist_clear_strobe)
    else $error("clear strobe length wrong");
  a_clear_first: assert property ($rose(hist_clear_strobe) |-> hist_clear_index == '0)
    else $error("clear index not starting at zero");
  a_clear_step: assert property (hist_clear_strobe && $past(hist_clear_strobe)
    |-> hist_clear_index == $past(hist_clear_index) + 1'b1)
    else $error("clear index not stepping");
  a_shutdown_release: assert property (shutdown_req |-> !pin0_oe)
    else $error("pin0 driven while a shutdown input");
  a_shutdown_follow: assert property (shutdown_req |-> !$past(pin0_i))
    else $error("shutdown without low pin");
  a_irq_toggle: assert property (pin1_oe && $past(pin1_oe) && $past(pin1_oe, 2)
    && $past(irq_level) != $past(irq_level, 2) |-> pin1_o != $past(pin1_o))
    else $error("pin1 not following interrupt");
  a_reset_idle: assert property ($fell(rst) |-> !hist_enable && !hist_mode_als && !pin1_oe && !pin0_oe)
    else $error("outputs not idle after reset");
  // Main scenarios
  c_clear: cover property ($rose(hist_clear_strobe));
  c_shutdown: cover property ($rose(shutdown_req));
  c_irq_drive: cover property (pin1_oe && pin1_o);
endmodule : ident_gpio_history_regs_asserts

bind ident_gpio_history_regs ident_gpio_history_regs_asserts #(.HIST_DEPTH(HIST_DEPTH)) chk_u (
  .sys_clk(sys_clk), .rst(rst), .nvs_load(nvs_load), .nvs_ident(nvs_ident), .irq_level(irq_level),
  .pin0_i(pin0_i), .pin0_oe(pin0_oe), .pin1_o(pin1_o), .pin1_oe(pin1_oe), .shutdown_req(shutdown_req),
  .hist_enable(hist_enable), .hist_mode_als(hist_mode_als), .hist_clear_strobe(hist_clear_strobe),
  .hist_clear_index(hist_clear_index), .model_code(model_code), .build_seconds(build_seconds)
);

/* File: dv/ident_gpio_history_regs_tb.sv */
// Self-checking bench for the register bank, driven through the two-wire host model.
// Assumes the device answers at the default bus address 0x2a.
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("FAIL %s exp %h got %h", n, e, g); end end
module ident_gpio_history_regs_tb;
  // ----
  // Signals and instances
  // ----
  logic sys_clk = 1'b0, rst = 1'b1, nvs_load = 1'b0, irq_level = 1'b0, pin0_i = 1'b0, pin1_i = 1'b0;
  sensor_regs_pkg::ident_t nvs_ident = '0;
  logic scl, host_low, sda_o, sda_oe, pin0_o, pin0_oe, pin1_o, pin1_oe, shutdown_req;
  logic hist_enable, hist_mode_als, hist_clear_strobe;
  logic [2:0] hist_clear_index;
  logic [7:0] model_code;
  logic [16:0] build_seconds;
  int fails = 0, comparisons = 0, cycles = 0, scount = 0;
  wire sda = !(sda_oe && !sda_o || host_low); // Pulled up unless pulled low
  i2c_host_model host_u (.sys_clk(sys_clk), .sda(sda), .scl(scl), .host_low(host_low));
  ident_gpio_history_regs dut_u (
    .sys_clk(sys_clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .nvs_load(nvs_load), .nvs_ident(nvs_ident), .irq_level(irq_level), .pin0_i(pin0_i), .pin0_o(pin0_o),
    .pin0_oe(pin0_oe), .pin1_i(pin1_i), .pin1_o(pin1_o), .pin1_oe(pin1_oe), .shutdown_req(shutdown_req),
    .hist_enable(hist_enable), .hist_mode_als(hist_mode_als), .hist_clear_strobe(hist_clear_strobe),
    .hist_clear_index(hist_clear_index), .model_code(model_code), .build_seconds(build_seconds)
  );
  // Clock, strobe count and hang guard
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (hist_clear_strobe === 1'b1) scount++;
    if (cycles == 60000) begin
      fails++;
      end_sim();
    end
  end
  // ----
  // Helpers
  // ----
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    host_u.write_reg(7'h2a, idx, d);
  endtask : wr
  task automatic rchk(input string n, input logic [15:0] idx, input logic [7:0] e);
    logic [7:0] v;
    host_u.read_reg(7'h2a, idx, v);
    `CHK(n, e, v)
  endtask : rchk
  task automatic end_sim();
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    rchk("pin0_config", 16'h0010, 8'h60);
    rchk("pin1_config", 16'h0011, 8'h20);
    rchk("history_control", 16'h0012, 8'h00);
    rchk("model_ident", 16'h0000, 8'h5a);
    rchk("model_rev_high", 16'h0001, 8'h05);
    rchk("module_rev_low", 16'h0004, 8'h07);
    `CHK("acks", 0, host_u.nacks)
    `CHK("shutdown_req", 1'b1, shutdown_req)
  endtask : t_reset
  task automatic t_nvm();
    @(posedge sys_clk);
    nvs_ident <= {8'hc3, 3'h4, 3'h7, 3'h6, 3'h0, 4'h7, 4'hc, 5'h1f, 3'h5, 16'ha55a};
    nvs_load <= 1'b1;
    @(posedge sys_clk);
    nvs_load <= 1'b0;
    settle();
    `CHK("build_seconds", 17'h14ab4, build_seconds)
    `CHK("model_code", 8'hc3, model_code)
    rchk("model_rev_high", 16'h0001, 8'h04);
    rchk("model_rev_low", 16'h0002, 8'h07);
    rchk("module_rev_high", 16'h0003, 8'h06);
    rchk("build_date_upper", 16'h0006, 8'h7c);
    rchk("build_date_lower", 16'h0007, 8'hfd);
    rchk("build_time_high", 16'h0008, 8'ha5);
    rchk("build_time_low", 16'h0009, 8'h5a);
  endtask : t_nvm
  task automatic t_write();
    int n;
    wr(16'h0000, 8'h3c);
    `CHK("model_code", 8'h3c, model_code)
    wr(16'h0001, 8'hff);
    rchk("model_rev_high", 16'h0001, 8'h07);
    wr(16'h0005, 8'hff);
    rchk("unmapped", 16'h0005, 8'h00);
    n = host_u.nacks;
    host_u.write_reg(7'h2b, 16'h0012, 8'h01);
    `CHK("wrong_address_nacks", n + 4, host_u.nacks)
    rchk("history_control", 16'h0012, 8'h00);
  endtask : t_write
  task automatic t_pins();
    wr(16'h0010, 8'h70);
    pin0_i <= 1'b1;
    settle();
    `CHK("pin0_oe", 1'b0, pin0_oe)
    `CHK("shutdown_req", 1'b0, shutdown_req)
    pin0_i <= 1'b0;
    wr(16'h0010, 8'h30);
    `CHK("pin0_oe", 1'b1, pin0_oe)
    `CHK("pin0_o", 1'b0, pin0_o)
    irq_level <= 1'b1;
    settle();
    `CHK("pin0_o", 1'b1, pin0_o)
    wr(16'h0011, 8'h10);
    `CHK("pin1_oe", 1'b1, pin1_oe)
    `CHK("pin1_o", 1'b0, pin1_o)
    irq_level <= 1'b0;
    settle();
    `CHK("pin1_o", 1'b1, pin1_o)
    wr(16'h0011, 8'h00);
    `CHK("pin1_oe", 1'b0, pin1_oe)
    wr(16'h0011, 8'hff);
    rchk("pin1_config", 16'h0011, 8'h3e);
    rchk("pin0_config", 16'h0010, 8'h30);
  endtask : t_pins
  task automatic t_hist();
    wr(16'h0012, 8'h02);
    `CHK("hist_mode_als", 1'b1, hist_mode_als)
    `CHK("hist_enable", 1'b0, hist_enable)
    wr(16'h0012, 8'h03);
    `CHK("hist_enable", 1'b1, hist_enable)
    scount = 0;
    wr(16'h0012, 8'h07);
    `CHK("clear_cycles", 8, scount)
    rchk("history_control", 16'h0012, 8'h03);
    wr(16'h0012, 8'h00);
    `CHK("hist_enable", 1'b0, hist_enable)
    `CHK("hist_mode_als", 1'b0, hist_mode_als)
  endtask : t_hist
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_nvm();
    t_write();
    t_pins();
    t_hist();
    end_sim();
  end
endmodule : ident_gpio_history_regs_tb
